// ---- logic/oesc_control.sv ----
`timescale 1ns/1ps
`include "oesc_map.svh"
// Behaviour
// - Disabled outputs float, never driven.
// - Per-output inversion gives 180 degrees.
// - CMOS pairs toggle both pins alike.
// - CMOS pair pins aligned or inverted.
// - Selection bit zero: pins gate outputs.
// - Selection bit one: per-output bits gate.
// - Pin codes map to output groups.
// - Ten output domains power down separately.
// - EEPROM values replace one-time memory values.
// - Serial writes accepted after init, lost on reset.
// - Either reset source holds the reset state.
// - Reset forces defaults and idle machines.
// - Serial port silent while in reset.
// - All outputs disabled during reset.
// - Reset clears all alarm bits.
// - Leave reset after both sources release.
// - Load memory block, then choose source.
// - Serial port and PLL start after load.
// - Lock, then sync dividers and start skew together.
// - Serial slave reaches every register.
// - Master only reads EEPROM, never writes.
// - Contend for bus before EEPROM read.
// - NACK or CRC error aborts, flags failure.
module oesc_control
(
   input wire logic clock,
   input wire logic rst,
   input wire logic por_active,
   input wire logic master_reset_n,
   input wire logic [1:0] oe_pins,
   input wire logic enable_source_select,
   input wire oesc_pkg::oesc_out_vec_type per_output_enable_bits,
   input wire oesc_pkg::oesc_out_vec_type output_invert,
   input wire oesc_pkg::oesc_out_vec_type cmos_mode,
   input wire oesc_pkg::oesc_out_vec_type cmos_pair_invert,
   input wire oesc_pkg::oesc_dom_vec_type domain_power_down,
   input wire logic [11:0] clock_sources,
   input wire logic eeprom_boot_enable,
   input wire logic otp_word_valid,
   input wire logic bus_granted,
   input wire logic eep_word_valid,
   input wire logic eep_nack,
   input wire logic eep_crc_error,
   input wire logic reg_write_strobe,
   input wire logic pll_locked,
   input wire logic alarm_event,
   output logic device_in_reset,
   output logic otp_load_active,
   output logic load_from_eeprom,
   output logic bus_request,
   output logic eep_read_active,
   output logic serial_port_enable,
   output logic reg_write_accept,
   output logic pll_lock_enable,
   output logic divider_sync,
   output logic skew_enable,
   output logic boot_failure_flag,
   output logic alarm_status,
   output logic [11:0] clock_outputs,
   output logic [11:0] clock_outputs_oe_n,
   output logic [11:0] complementary_output_pin,
   output logic [11:0] complementary_output_oe_n
);
   import oesc_pkg::*;

   // ***************************************************
   // Reset synchroniser
   // ***************************************************
   logic mr_s1;
   logic mr_s2;
   logic mr_s3;
   logic mr_stable;
   logic por_s1;
   logic por_s2;
   logic por_s3;
   logic por_stable;
   logic in_reset;

   always_ff @(posedge clock)
   begin
      mr_s1 <= master_reset_n;
      mr_s2 <= mr_s1;
      mr_s3 <= mr_s2;
      por_s1 <= por_active;
      por_s2 <= por_s1;
      por_s3 <= por_s2;
   end

   // Change counts once the last two stages agree
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mr_stable <= 1'b0;
         por_stable <= 1'b1;
      end
      else
      begin
         if (mr_s2 == mr_s3)
            mr_stable <= mr_s3;
         if (por_s2 == por_s3)
            por_stable <= por_s3;
      end
   end

   // Either source holds reset; exit once both have cleared
   assign in_reset = rst || por_stable || !mr_stable;

   always_ff @(posedge clock)
   begin
      if (rst)
         device_in_reset <= 1'b1;
      else
         device_in_reset <= in_reset;
   end

   // ***************************************************
   // Enable pin synchroniser
   // ***************************************************
   logic [1:0] oe_s1;
   logic [1:0] oe_s2;
   logic [1:0] oe_s3;
   logic [1:0] oe_stable;

   // Board pins run free of the core clock
   always_ff @(posedge clock)
   begin
      oe_s1 <= oe_pins;
      oe_s2 <= oe_s1;
      oe_s3 <= oe_s2;
   end

   always_ff @(posedge clock)
   begin
      if (in_reset)
         oe_stable <= `OESC_OE_PINS_OFF;
      else if (oe_s2 == oe_s3)
         oe_stable <= oe_s3;
   end

   // ***************************************************
   // Start-up sequencer
   // ***************************************************
   oesc_state_type state;
   oesc_state_type next_state;
   logic [7:0] word_count;

   always_comb
   begin
      next_state = state;
      unique case (state)
         oesc_st_reset:
            next_state = oesc_st_otp;
         oesc_st_otp:
            if (otp_word_valid && word_count == `OESC_OTP_WORDS - `OESC_ONE_WORD)
               next_state = eeprom_boot_enable ? oesc_st_eep_req : oesc_st_lock;
         oesc_st_eep_req:
            if (bus_granted)
               next_state = oesc_st_eep;
         oesc_st_eep:
            if (eep_nack || eep_crc_error)
               next_state = oesc_st_lock;
            else if (eep_word_valid && word_count == `OESC_EEP_WORDS - `OESC_ONE_WORD)
               next_state = oesc_st_lock;
         oesc_st_lock:
            if (pll_locked)
               next_state = oesc_st_run;
         oesc_st_run:
            next_state = oesc_st_run;
         default:
            next_state = oesc_st_reset;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (in_reset)
         state <= oesc_st_reset;
      else
         state <= next_state;
   end

   // OTP counts from zero; EEPROM picks up after the OTP block
   always_ff @(posedge clock)
   begin
      if (in_reset || state == oesc_st_reset)
         word_count <= `OESC_WORD_ZERO;
      else if ((state == oesc_st_otp && otp_word_valid)
         || (state == oesc_st_eep && eep_word_valid))
         word_count <= word_count + `OESC_ONE_WORD;
   end

   // Load phase indicators
   always_ff @(posedge clock)
   begin
      if (in_reset)
      begin
         otp_load_active <= 1'b0;
         load_from_eeprom <= 1'b0;
         eep_read_active <= 1'b0;
      end
      else
      begin
         otp_load_active <= next_state == oesc_st_otp;
         load_from_eeprom <= next_state == oesc_st_eep;
         eep_read_active <= next_state == oesc_st_eep;
      end
   end

   // Bus held from request through the whole read
   always_ff @(posedge clock)
   begin
      if (in_reset)
         bus_request <= 1'b0;
      else
         bus_request <= next_state == oesc_st_eep_req || next_state == oesc_st_eep;
   end

   // Port and PLL wait for the load to finish or abort
   always_ff @(posedge clock)
   begin
      if (in_reset)
      begin
         serial_port_enable <= 1'b0;
         pll_lock_enable <= 1'b0;
      end
      else
      begin
         serial_port_enable <= next_state == oesc_st_lock || next_state == oesc_st_run;
         pll_lock_enable <= next_state == oesc_st_lock || next_state == oesc_st_run;
      end
   end

   always_ff @(posedge clock)
   begin
      if (in_reset)
         skew_enable <= 1'b0;
      else
         skew_enable <= next_state == oesc_st_run;
   end

   // Writes only count once the port is open
   always_ff @(posedge clock)
   begin
      if (in_reset)
         reg_write_accept <= 1'b0;
      else
         reg_write_accept <= reg_write_strobe && serial_port_enable;
   end

   // Single pulse on the edge that leaves the lock wait
   always_ff @(posedge clock)
   begin
      if (in_reset)
         divider_sync <= 1'b0;
      else
         divider_sync <= state == oesc_st_lock && pll_locked;
   end

   // ***************************************************
   // Status
   // ***************************************************
   // Sticky until the next reset
   always_ff @(posedge clock)
   begin
      if (in_reset)
         boot_failure_flag <= 1'b0;
      else if (state == oesc_st_eep && (eep_nack || eep_crc_error))
         boot_failure_flag <= 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (in_reset)
         alarm_status <= 1'b0;
      else if (alarm_event)
         alarm_status <= 1'b1;
   end

   // ***************************************************
   // Output enables and drive
   // ***************************************************
   oesc_out_vec_type pin_enable;
   oesc_out_vec_type chosen_enable;
   oesc_out_vec_type powered;

   always_comb
   begin
      pin_enable = `OESC_OUT_DEFAULT;
      if (oe_stable[0])
         pin_enable = pin_enable | `OESC_OE_GRPA_MASK;
      if (oe_stable[1])
         pin_enable = pin_enable | `OESC_OE_GRPB_MASK;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `OESC_NUM_OUT; gi = gi + 1)
      begin : g_out
         // Outputs 8-9 share domain 8, 10-11 share domain 9
         localparam int dom = (gi < `OESC_NUM_FRAC_DOM) ? gi
            : `OESC_NUM_FRAC_DOM + (gi - `OESC_NUM_FRAC_DOM) / `OESC_OUTS_PER_INT_DOM;
         assign powered[gi] = !domain_power_down[dom];
      end
   endgenerate

   assign chosen_enable = enable_source_select ? per_output_enable_bits : pin_enable;

   // Output levels
   always_ff @(posedge clock)
   begin
      if (in_reset)
      begin
         clock_outputs <= `OESC_OUT_DEFAULT;
         complementary_output_pin <= `OESC_OUT_DEFAULT;
      end
      else
      begin
         clock_outputs <= clock_sources ^ output_invert;
         // CMOS: same level unless pair inversion; otherwise differential
         complementary_output_pin <= (clock_sources ^ output_invert)
            ^ ~(cmos_mode & ~cmos_pair_invert);
      end
   end

   // Both pins of a pair share one enable
   always_ff @(posedge clock)
   begin
      if (in_reset)
      begin
         clock_outputs_oe_n <= ~`OESC_OUT_DEFAULT;
         complementary_output_oe_n <= ~`OESC_OUT_DEFAULT;
      end
      else
      begin
         clock_outputs_oe_n <= ~(chosen_enable & powered);
         complementary_output_oe_n <= ~(chosen_enable & powered);
      end
   end
endmodule

// ---- common/oesc_map.svh ----
`ifndef OESC_MAP_SVH
`define OESC_MAP_SVH
`define OESC_NUM_OUT 12
`define OESC_NUM_DOM 10
`define OESC_OE_GRPA_MASK 12'h00f
`define OESC_OE_GRPB_MASK 12'hff0
`define OESC_OUT_DEFAULT 12'h000
`define OESC_POL_DEFAULT 12'h000
`define OESC_PD_DEFAULT 10'h000
`define OESC_OTP_WORDS 8'h08
`define OESC_EEP_WORDS 8'hb4
`define OESC_WORD_ZERO 8'h00
`define OESC_ONE_WORD 8'h01
`define OESC_OE_PINS_OFF 2'h0
`define OESC_NUM_FRAC_DOM 8
`define OESC_OUTS_PER_INT_DOM 2
`endif

// ---- common/oesc_pkg.sv ----
package oesc_pkg;
   typedef enum logic [2:0]
   {
      oesc_st_reset = 3'b000,
      oesc_st_otp = 3'b001,
      oesc_st_eep_req = 3'b010,
      oesc_st_eep = 3'b011,
      oesc_st_lock = 3'b100,
      oesc_st_run = 3'b101
   } oesc_state_type;
   typedef logic [11:0] oesc_out_vec_type;
   typedef logic [9:0] oesc_dom_vec_type;
endpackage

// ---- tb/oesc_control_monitor.sv ----
`timescale 1ns/1ps
module oesc_control_monitor
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reg_write_strobe,
   input wire logic eep_nack,
   input wire logic eep_crc_error,
   input wire logic device_in_reset,
   input wire logic reg_write_accept,
   input wire logic serial_port_enable,
   input wire logic pll_lock_enable,
   input wire logic otp_load_active,
   input wire logic eep_read_active,
   input wire logic bus_request,
   input wire logic divider_sync,
   input wire logic boot_failure_flag,
   input wire logic alarm_status,
   input wire logic [11:0] clock_outputs_oe_n,
   input wire logic [11:0] complementary_output_oe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_reset_float: assert property (device_in_reset && $past(device_in_reset) |->
      &clock_outputs_oe_n && &complementary_output_oe_n) else $error("output driven in reset");
   chk_reset_clear: assert property (device_in_reset && $past(device_in_reset) |->
      !alarm_status && !boot_failure_flag) else $error("status not cleared in reset");
   chk_port_silent: assert property (reg_write_strobe && !serial_port_enable |=>
      !reg_write_accept) else $error("write accepted before port open");
   chk_write_taken: assert property (reg_write_strobe && serial_port_enable |=>
      reg_write_accept) else $error("write not accepted");
   chk_pll_after_load: assert property (pll_lock_enable |->
      !otp_load_active && !eep_read_active) else $error("pll started during load");
   chk_sync_single: assert property (divider_sync |=> !divider_sync)
      else $error("divider sync longer than one cycle");
   chk_grant_first: assert property ($rose(eep_read_active) |-> $past(bus_request))
      else $error("eeprom read without bus request");
   chk_nack_abort: assert property (eep_read_active && eep_nack |=>
      boot_failure_flag && !eep_read_active) else $error("nack did not abort");
   chk_crc_abort: assert property (eep_read_active && eep_crc_error |=>
      boot_failure_flag && !eep_read_active) else $error("checksum error did not abort");
   cover property (divider_sync);
   cover property (boot_failure_flag);
   cover property (reg_write_accept);
endmodule
bind oesc_control oesc_control_monitor oesc_control_monitor_i (.clock, .rst, .reg_write_strobe,
   .eep_nack, .eep_crc_error, .device_in_reset, .reg_write_accept, .serial_port_enable,
   .pll_lock_enable,
   .otp_load_active, .eep_read_active, .bus_request, .divider_sync, .boot_failure_flag,
   .alarm_status, .clock_outputs_oe_n, .complementary_output_oe_n);

// ---- tb/oesc_board_model.sv ----
`timescale 1ns/1ps
module oesc_board_model
(
   input wire logic clock,
   input wire logic otp_load_active,
   input wire logic bus_request,
   input wire logic eep_read_active,
   input wire logic nack_mode,
   output logic otp_word_valid = 1'b0,
   output logic bus_granted = 1'b0,
   output logic eep_word_valid = 1'b0,
   output logic eep_nack = 1'b0
);
   logic [3:0] wait_count = 4'h0;
   // Grant is held back a few cycles to model a busy bus
   always @(negedge clock)
   begin
      wait_count <= bus_request ? wait_count + 4'h1 : 4'h0;
      otp_word_valid <= otp_load_active;
      bus_granted <= (bus_request && wait_count > 4'h2) || (bus_granted && eep_read_active);
      eep_word_valid <= eep_read_active && !nack_mode;
      eep_nack <= eep_read_active && nack_mode && !eep_nack;
   end
endmodule

// ---- tb/oesc_control_tb_top.sv ----
`timescale 1ns/1ps
`include "oesc_map.svh"
module oesc_control_tb_top;
   import oesc_pkg::*;
   logic clock = 1'b0, rst = 1'b1, por_active = 1'b0, master_reset_n = 1'b1, nack_mode = 1'b0;
   logic [1:0] oe_pins = 2'h3;
   logic enable_source_select = 1'b0, eeprom_boot_enable = 1'b0, reg_write_strobe = 1'b0;
   logic pll_locked = 1'b0, alarm_event = 1'b0, eep_crc_error = 1'b0;
   oesc_out_vec_type per_output_enable_bits = 12'h000, output_invert = 12'h000;
   oesc_out_vec_type cmos_mode = 12'h000, cmos_pair_invert = 12'h000;
   oesc_dom_vec_type domain_power_down = 10'h000;
   logic [11:0] clock_sources = 12'h000;
   logic otp_word_valid, bus_granted, eep_word_valid, eep_nack, device_in_reset, otp_load_active;
   logic load_from_eeprom, bus_request, eep_read_active, serial_port_enable, reg_write_accept;
   logic pll_lock_enable, divider_sync, skew_enable, boot_failure_flag, alarm_status;
   logic [11:0] clock_outputs, clock_outputs_oe_n, complementary_output_pin;
   logic [11:0] complementary_output_oe_n;
   int errors = 0, checks_done = 0;
   always #20 clock = ~clock;
   oesc_control oesc_control_i (.clock, .rst, .por_active, .master_reset_n, .oe_pins,
      .enable_source_select, .per_output_enable_bits, .output_invert, .cmos_mode,
      .cmos_pair_invert, .domain_power_down, .clock_sources, .eeprom_boot_enable,
      .otp_word_valid, .bus_granted, .eep_word_valid, .eep_nack, .eep_crc_error,
      .reg_write_strobe, .pll_locked, .alarm_event, .device_in_reset, .otp_load_active,
      .load_from_eeprom, .bus_request, .eep_read_active, .serial_port_enable,
      .reg_write_accept, .pll_lock_enable, .divider_sync, .skew_enable, .boot_failure_flag,
      .alarm_status, .clock_outputs, .clock_outputs_oe_n, .complementary_output_pin,
      .complementary_output_oe_n);
   oesc_board_model oesc_board_model_i (.clock, .otp_load_active, .bus_request,
      .eep_read_active, .nack_mode, .otp_word_valid, .bus_granted, .eep_word_valid, .eep_nack);
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
         errors++;
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic end_sim;
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic boot(input logic eep);
      int n;
      eeprom_boot_enable = eep;
      master_reset_n = 1'b1;
      rst = 1'b0;
      cycles(6);
      reg_write_strobe = 1'b1;
      cycles(1);
      reg_write_strobe = 1'b0;
      check("early_write", {11'h0, reg_write_accept}, 12'h000);
      check("otp_busy", {11'h0, otp_load_active}, 12'h001);
      for (n = 0; serial_port_enable !== 1'b1 && n < 300; n++) cycles(1);
      check("port_open", {11'h0, serial_port_enable}, 12'h001);
   endtask
   task automatic t_otp;
      int n;
      boot(1'b0);
      check("boot_ok", {11'h0, boot_failure_flag}, 12'h000);
      reg_write_strobe = 1'b1;
      cycles(1);
      reg_write_strobe = 1'b0;
      check("write_accept", {11'h0, reg_write_accept}, 12'h001);
      pll_locked = 1'b1;
      for (n = 0; divider_sync !== 1'b1 && n < 50; n++) cycles(1);
      check("div_sync", {11'h0, divider_sync}, 12'h001);
      cycles(2);
      check("skew_on", {11'h0, skew_enable}, 12'h001);
   endtask
   task automatic t_pins;
      logic [11:0] grp [4];
      grp = '{12'h000, 12'h00f, 12'hff0, 12'hfff};
      per_output_enable_bits = 12'h5a5;
      for (int c = 0; c < 4; c++)
      begin
         oe_pins = c[1:0];
         cycles(6);
         check("pin_oe", clock_outputs_oe_n, ~grp[c]);
      end
      enable_source_select = 1'b1;
      cycles(3);
      check("reg_oe", clock_outputs_oe_n, 12'ha5a);
      per_output_enable_bits = 12'hfff;
      domain_power_down = 10'h100;
      cycles(3);
      check("pd_oe", clock_outputs_oe_n, 12'h300);
      check("pd_comp_oe", complementary_output_oe_n, 12'h300);
      domain_power_down = 10'h000;
   endtask
   task automatic t_data;
      clock_sources = 12'h0f0;
      output_invert = 12'h00f;
      cmos_mode = 12'hf00;
      cycles(3);
      check("q_level", clock_outputs, 12'h0ff);
      check("nq_level", complementary_output_pin, 12'h000);
      cmos_pair_invert = 12'h100;
      cycles(3);
      check("nq_inv", complementary_output_pin, 12'h100);
   endtask
   task automatic t_reset;
      alarm_event = 1'b1;
      cycles(1);
      alarm_event = 1'b0;
      cycles(2);
      check("alarm_set", {11'h0, alarm_status}, 12'h001);
      master_reset_n = 1'b0;
      cycles(8);
      check("in_reset", {11'h0, device_in_reset}, 12'h001);
      check("rst_oe", clock_outputs_oe_n, 12'hfff);
      check("rst_alarm", {11'h0, alarm_status}, 12'h000);
      reg_write_strobe = 1'b1;
      cycles(1);
      reg_write_strobe = 1'b0;
      check("reset_write", {11'h0, reg_write_accept}, 12'h000);
      nack_mode = 1'b1;
      boot(1'b1);
      check("boot_fail", {11'h0, boot_failure_flag}, 12'h001);
   endtask
   task automatic t_eep(input logic crc);
      int n;
      logic [11:0] words;
      words = crc ? 12'h001 : {4'h0, `OESC_EEP_WORDS - `OESC_OTP_WORDS};
      nack_mode = 1'b0;
      master_reset_n = 1'b0;
      cycles(8);
      eeprom_boot_enable = 1'b1;
      master_reset_n = 1'b1;
      for (n = 0; eep_read_active !== 1'b1 && n < 50; n++) cycles(1);
      check("eep_busy", {10'h0, load_from_eeprom, bus_request}, 12'h003);
      eep_crc_error = crc;
      for (n = 0; serial_port_enable !== 1'b1 && n < 300; n++) cycles(1);
      eep_crc_error = 1'b0;
      check("eep_words", n[11:0], words);
      check("eep_fail", {11'h0, boot_failure_flag}, {11'h0, crc});
   endtask
   initial
   begin
      #400000;
      errors++;
      end_sim();
   end
   initial
   begin
      cycles(6);
      t_otp();
      t_pins();
      t_data();
      t_reset();
      t_eep(1'b0);
      t_eep(1'b1);
      end_sim();
   end
endmodule
